// File: uir_ir_config.sv
`timescale 1ns/1ns
module uir_ir_config (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [2:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output logic [7:0] regRdData,
   input wire logic extendedMode,
   input wire uir_pkg::uir_mode_t extModeSel,
   input wire logic loopbackEn,
   input wire logic irTxActive,
   input wire logic irRxPrimary,
   input wire logic irRxAux,
   input wire logic [7:0] msrRaw,
   input wire logic msIrqRaw,
   input wire logic baudTick16,
   input wire logic sirPulseReq,
   input wire logic cirDemodEn,
   output uir_pkg::uir_mode_t activeMode,
   output logic irRxData,
   output logic [7:0] modemStatusReg,
   output logic modemStatusIrq,
   output logic askTxModEn,
   output logic askRxDemodEn,
   output logic sirTxPulse,
   output logic [4:0] demodCenterFreq,
   output logic [2:0] demodBandwidth,
   output logic rxHighSpeedCarrier,
   output logic carrierAccepted,
   output logic [8:0] txCarrierKhz,
   output logic [2:0] transceiverModeOutputs,
   output logic transceiverModeOe,
   output logic [7:0] linkControlReg
);
   import uir_pkg::*;

   // -------------------------------------------------------------------
   // registers
   // -------------------------------------------------------------------
   logic [7:0] legacySel_ff, basic_ff, askCtl_ff, sirPw_ff, rxDc_ff;
   logic [7:0] txMc_ff, cirCfg_ff, cfg1_ff, cfg3_ff, cfg4_ff;
   logic [7:0] link_ff, rdData_ff;
   logic [2:0] bank_ff;
   logic [1:0] rxPrimSync_ff, rxAuxSync_ff;
   logic rxLast_ff, accept_ff, pulse_ff;
   logic [11:0] period_ff;
   logic [7:0] pulseCnt_ff;
   uir_pulse_t pstate_ff, nxt_pstate;
   logic [7:0] nxt_pulseCnt;

   // write decode, bank-qualified; offset 03h is shared by every bank
   wire wrLink = regWrEn && regAddr == OFS_LINK;
   wire wrLegacy = regWrEn && bank_ff == BANK_LEGACY && regAddr == OFS_SEL;
   wire wrBasic = regWrEn && bank_ff == BANK_BASIC && regAddr == OFS_CFG1;
   wire wrAsk = regWrEn && bank_ff == BANK_PHY && regAddr == OFS_CTL;
   wire wrSirPw = regWrEn && bank_ff == BANK_PHY && regAddr == OFS_SEL;
   wire wrCir = regWrEn && bank_ff == BANK_CIR;
   wire isBankSel = regWrData[BANK_FLAG_BIT];

   // -------------------------------------------------------------------
   // register file
   // -------------------------------------------------------------------
   // reserved bits are stripped on write so they always read zero
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         legacySel_ff <= RST_LEGACY;
         basic_ff <= RST_BASIC;
         askCtl_ff <= RST_ASKCTL;
         sirPw_ff <= RST_SIRPW;
      end else begin
         if (wrLegacy) legacySel_ff <= regWrData & MASK_LEGACY;
         if (wrBasic) basic_ff <= regWrData & MASK_BASIC;
         if (wrAsk) askCtl_ff <= regWrData & MASK_ASKCTL;
         if (wrSirPw) sirPw_ff <= regWrData & MASK_SIRPW;
      end
   end

   // consumer-IR and transceiver bank
   // field layouts here are only partly defined, so all eight bits are kept
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rxDc_ff <= RST_RXDC;
         txMc_ff <= RST_TXMC;
         cirCfg_ff <= RST_ZERO;
         cfg1_ff <= RST_ZERO;
         cfg3_ff <= RST_ZERO;
         cfg4_ff <= RST_ZERO;
      end else if (wrCir) begin
         if (regAddr == OFS_CTL) rxDc_ff <= regWrData;
         if (regAddr == OFS_TXM) txMc_ff <= regWrData;
         if (regAddr == OFS_SEL) cirCfg_ff <= regWrData;
         if (regAddr == OFS_CFG1) cfg1_ff <= regWrData;
         if (regAddr == OFS_CFG3) cfg3_ff <= regWrData;
         if (regAddr == OFS_CFG4) cfg4_ff <= regWrData;
      end
   end


   // link control and bank select share one location
   // a bank select write leaves the link byte untouched
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         link_ff <= RST_ZERO;
         bank_ff <= 3'h0;
      end else if (wrLink) begin
         if (isBankSel) bank_ff <= regWrData[2:0];
         else begin
            link_ff <= regWrData;
            bank_ff <= 3'h0;
         end
      end
   end
   assign linkControlReg = link_ff;

   // -------------------------------------------------------------------
   // read path
   // -------------------------------------------------------------------
   // unmapped or reserved offsets fall to zero
   logic [7:0] rdMux;
   always_comb begin
      rdMux = 8'h00;
      if (regAddr == OFS_LINK) rdMux = link_ff;
      else case (bank_ff)
         BANK_LEGACY: if (regAddr == OFS_SEL) rdMux = legacySel_ff;
         BANK_BASIC: if (regAddr == OFS_CFG1) rdMux = basic_ff;
         BANK_PHY: begin
            if (regAddr == OFS_CTL) rdMux = askCtl_ff;
            if (regAddr == OFS_SEL) rdMux = sirPw_ff;
         end
         BANK_CIR: case (regAddr)
            OFS_CTL: rdMux = rxDc_ff;
            OFS_TXM: rdMux = txMc_ff;
            OFS_SEL: rdMux = cirCfg_ff;
            OFS_CFG1: rdMux = cfg1_ff;
            OFS_CFG3: rdMux = cfg3_ff;
            OFS_CFG4: rdMux = cfg4_ff;
            default: rdMux = 8'h00;
         endcase
         default: rdMux = 8'h00;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) rdData_ff <= 8'h00;
      else rdData_ff <= regRdEn ? rdMux : 8'h00;
   end
   assign regRdData = rdData_ff;

   // -------------------------------------------------------------------
   // mode selection and modem status
   // -------------------------------------------------------------------
   wire uir_mode_t legacyMode = uir_mode_t'(legacySel_ff[POS_IFSEL +: 2]);
   assign activeMode = extendedMode ? extModeSel : legacyMode;
   wire irMode = activeMode == MODE_ASK || activeMode == MODE_SIR;
   wire askMode = activeMode == MODE_ASK;
   // in serial mode the select bit has no effect at all
   wire msFixed = irMode && basic_ff[POS_MSSEL];
   assign modemStatusReg = msFixed ? MSR_FIXED : msrRaw;
   // loopback feeds msIrqRaw from the control bits; same gate applies
   assign modemStatusIrq = msIrqRaw && !msFixed;
   assign askTxModEn = askMode && !askCtl_ff[POS_MODDIS];
   assign askRxDemodEn = askMode && !askCtl_ff[POS_DEMDIS];

   // -------------------------------------------------------------------
   // receive path
   // -------------------------------------------------------------------
   // both pins are asynchronous; only the second flop is used
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rxPrimSync_ff <= 2'b00;
         rxAuxSync_ff <= 2'b00;
      end else begin
         rxPrimSync_ff <= {rxPrimSync_ff[0], irRxPrimary};
         rxAuxSync_ff <= {rxAuxSync_ff[0], irRxAux};
      end
   end
   wire rxPin = basic_ff[POS_AUXRX] ? rxAuxSync_ff[1] : rxPrimSync_ff[1];
   // half duplex optics echo the transmitter, so mask while sending
   wire rxMasked = irTxActive && !basic_ff[POS_FDPLX] && !loopbackEn;
   assign irRxData = irMode && !rxMasked && rxPin;

   // -------------------------------------------------------------------
   // receive demodulator window
   // -------------------------------------------------------------------
   wire demodOn = askMode ? askRxDemodEn : cirDemodEn;
   assign rxHighSpeedCarrier = cirCfg_ff[POS_RXHS];
   assign demodCenterFreq = demodOn ? rxDc_ff[4:0] : 5'h00;
   assign demodBandwidth = demodOn ? rxDc_ff[POS_BW +: 3] : 3'h0;

   // nominal subcarrier period in ref cycles; an approximation of the
   // centre tables, kept linear in frequency to stay small
   function automatic logic [11:0] nomPeriod(input logic [4:0] code, input logic hs, input logic ask);
      logic [16:0] khz;
      khz = 17'd0;
      if (ask) khz = 17'd500;
      else if (hs) khz = 17'd400 + 17'(code) * 17'd8;
      else khz = 17'd27 + 17'(code);
      // slow carriers exceed the 12-bit period counter, so pin them at its ceiling
      if (17'(REF_KHZ) / khz > 17'h00FFF) nomPeriod = 12'hFFF;
      else nomPeriod = 12'(17'(REF_KHZ) / khz);
   endfunction

   wire [11:0] nomCyc = nomPeriod(demodCenterFreq, rxHighSpeedCarrier, askMode);
   wire [11:0] halfWin = 12'((15'(nomCyc) * 15'(demodBandwidth)) >> 4);
   wire rxRise = rxPin && !rxLast_ff;
   // window sums are one bit wider so a wide bandwidth cannot wrap around
   wire [12:0] periodNow = {1'b0, period_ff} + 13'h0001;
   wire [12:0] winLo = {1'b0, nomCyc} - {1'b0, halfWin};
   wire [12:0] winHi = {1'b0, nomCyc} + {1'b0, halfWin};
   wire inWindow = periodNow >= winLo && periodNow <= winHi;

   // period measured between rising edges; saturates on a dead line
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rxLast_ff <= 1'b0;
         period_ff <= 12'h000;
         accept_ff <= 1'b0;
      end else begin
         rxLast_ff <= rxPin;
         if (rxRise) begin
            period_ff <= 12'h000;
            accept_ff <= demodOn && inWindow;
         end else if (period_ff != 12'hFFF) period_ff <= period_ff + 12'h001;
      end
   end
   assign carrierAccepted = accept_ff;

   // -------------------------------------------------------------------
   // transmit carrier and transceiver mode pins
   // -------------------------------------------------------------------
   // low codes 3..29 span 30..56 kHz; three high codes, others reserved
   function automatic logic [8:0] carrierKhz(input logic [4:0] code, input logic hs);
      carrierKhz = 9'h000;
      if (!hs && code >= 5'h03 && code <= 5'h1D) carrierKhz = 9'(code) + 9'h01B;
      else if (hs && code == 5'h03) carrierKhz = 9'h190;
      else if (hs && code == 5'h08) carrierKhz = 9'h1C2;
      else if (hs && code == 5'h0B) carrierKhz = 9'h1E0;
   endfunction
   assign txCarrierKhz = carrierKhz(txMc_ff[4:0], cirCfg_ff[POS_TXHS]);

   wire autoCfg = cfg1_ff[POS_AUTOCFG];
   assign transceiverModeOe = cfg4_ff[POS_MODEOE];
   assign transceiverModeOutputs = (autoCfg && !irMode) ? 3'h0 : cfg1_ff[2:0];

   // -------------------------------------------------------------------
   // SIR pulse shaper
   // -------------------------------------------------------------------

   // reserved width codes fall back to the 3/16 width
   // the fixed width counts ref cycles, so it is exact only at 125 MHz
   wire fixedWidth = sirPw_ff[3:0] == SPW_FIXED;
   always_comb begin
      nxt_pstate = pstate_ff;
      nxt_pulseCnt = pulseCnt_ff;
      case (pstate_ff)
         PS_IDLE: if (sirPulseReq && activeMode == MODE_SIR) begin
            nxt_pstate = fixedWidth ? PS_FIXED : PS_FRAC;
            nxt_pulseCnt = fixedWidth ? 8'(SIR_FIXED_CYC - 1) : 8'(SIR_FRAC_TICKS);
         end
         PS_FRAC: if (baudTick16) begin
            nxt_pulseCnt = pulseCnt_ff - 8'h01;
            if (pulseCnt_ff == 8'h01) nxt_pstate = PS_IDLE;
         end
         PS_FIXED: begin
            nxt_pulseCnt = pulseCnt_ff - 8'h01;
            if (pulseCnt_ff == 8'h00) nxt_pstate = PS_IDLE;
         end
         default: nxt_pstate = PS_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pstate_ff <= PS_IDLE;
         pulseCnt_ff <= 8'h00;
         pulse_ff <= 1'b0;
      end else begin
         pstate_ff <= nxt_pstate;
         pulseCnt_ff <= nxt_pulseCnt;
         pulse_ff <= nxt_pstate != PS_IDLE;
      end
   end
   assign sirTxPulse = pulse_ff;

   // -------------------------------------------------------------------
   // checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   logic [8:0] pulseLen_ff;
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) pulseLen_ff <= 9'h000;
      else pulseLen_ff <= sirTxPulse ? pulseLen_ff + 9'h001 : 9'h000;
   end

   sequence fixedStart_s;
      pstate_ff == PS_IDLE && sirPulseReq && activeMode == MODE_SIR && fixedWidth;
   endsequence

   legacy_mode_a: assert property (!extendedMode |-> activeMode == legacyMode)
      else $error("legacy select not applied");
   ext_ignore_a: assert property (extendedMode && $past(extendedMode) && $stable(extModeSel)
      && $changed(legacySel_ff) |-> $stable(activeMode))
      else $error("legacy select leaked in extended mode");
   msr_fixed_a: assert property (irMode && basic_ff[POS_MSSEL] |-> modemStatusReg == 8'h30 && !modemStatusIrq)
      else $error("fixed status readback wrong");
   msr_serial_a: assert property (!irMode |-> modemStatusReg == msrRaw && modemStatusIrq == msIrqRaw)
      else $error("serial status altered");
   rx_mask_a: assert property (irTxActive && !basic_ff[POS_FDPLX] && !loopbackEn |-> !irRxData)
      else $error("receiver open during half duplex send");
   ask_mod_a: assert property (askMode && askCtl_ff[POS_MODDIS] |-> !askTxModEn)
      else $error("modulation not disabled");
   fixed_width_a: assert property (fixedStart_s |=> sirTxPulse [*8])
      else $error("fixed pulse too short");
   fixed_end_a: assert property ($fell(sirTxPulse) && $past(pstate_ff, 2) == PS_FIXED
      |-> pulseLen_ff == 9'(SIR_FIXED_CYC))
      else $error("fixed pulse length not 200 cycles");
   mode_pins_a: assert property (autoCfg && !irMode |-> transceiverModeOutputs == 3'h0)
      else $error("mode pins not low");
   link_shared_a: assert property (wrLink && !isBankSel |=> link_ff == $past(regWrData) && bank_ff == 3'h0)
      else $error("link write lost");
   demod_off_a: assert property (!demodOn |-> demodCenterFreq == 5'h00 ##1 !carrierAccepted || !$past(rxRise))
      else $error("demod fields used while disabled");
   read_late_a: assert property (regRdEn && regAddr == OFS_LINK |=> regRdData == link_ff)
      else $error("link read wrong");
   ask_demod_a: assert property (askMode && askCtl_ff[POS_DEMDIS] |-> !askRxDemodEn)
      else $error("demodulation not disabled");

   // reserved offsets of the legacy bank must read back as zero
   resv_read_a: assert property (regRdEn && bank_ff == BANK_LEGACY && regAddr != OFS_SEL
      && regAddr != OFS_LINK |=> regRdData == 8'h00)
      else $error("reserved offset read nonzero");

   // a pulse request outside SIR mode must be dropped
   sir_only_a: assert property (activeMode != MODE_SIR && pstate_ff == PS_IDLE |=> !sirTxPulse)
      else $error("pulse sent outside SIR mode");

   sequence rxEdgeOff_s;
      rxRise && !demodOn;
   endsequence
   edge_off_a: assert property (rxEdgeOff_s |=> !carrierAccepted)
      else $error("carrier accepted while demod disabled");
endmodule

// File: uir_pkg.sv
package uir_pkg;
   // -------------------------------------------------------------------
   // register map
   // -------------------------------------------------------------------
   localparam logic [2:0] OFS_CTL = 3'h0;
   localparam logic [2:0] OFS_TXM = 3'h1;
   localparam logic [2:0] OFS_SEL = 3'h2;
   localparam logic [2:0] OFS_LINK = 3'h3;
   localparam logic [2:0] OFS_CFG1 = 3'h4;
   localparam logic [2:0] OFS_CFG3 = 3'h6;
   localparam logic [2:0] OFS_CFG4 = 3'h7;
   localparam logic [2:0] BANK_LEGACY = 3'h4;
   localparam logic [2:0] BANK_BASIC = 3'h5;
   localparam logic [2:0] BANK_PHY = 3'h6;
   localparam logic [2:0] BANK_CIR = 3'h7;
   localparam int BANK_FLAG_BIT = 7;
   // -------------------------------------------------------------------
   // reset values and writable-bit masks
   // -------------------------------------------------------------------
   localparam logic [7:0] RST_LEGACY = 8'h00;
   localparam logic [7:0] RST_BASIC = 8'h02;
   localparam logic [7:0] RST_ASKCTL = 8'h20;
   localparam logic [7:0] RST_SIRPW = 8'h00;
   localparam logic [7:0] RST_RXDC = 8'h29;
   localparam logic [7:0] RST_TXMC = 8'h69;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] MASK_LEGACY = 8'h0C;
   localparam logic [7:0] MASK_BASIC = 8'h13;
   localparam logic [7:0] MASK_ASKCTL = 8'hE0;
   localparam logic [7:0] MASK_SIRPW = 8'h0F;
   localparam logic [7:0] MSR_FIXED = 8'h30;
   // -------------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------------
   localparam int POS_IFSEL = 2;
   localparam int POS_FDPLX = 0;
   localparam int POS_MSSEL = 1;
   localparam int POS_AUXRX = 4;
   localparam int POS_MODDIS = 6;
   localparam int POS_DEMDIS = 7;
   localparam int POS_BW = 5;
   localparam int POS_RXHS = 5;
   localparam int POS_TXHS = 6;
   localparam int POS_AUTOCFG = 3;
   localparam int POS_MODEOE = 0;
   localparam logic [3:0] SPW_FRAC = 4'h0;
   localparam logic [3:0] SPW_FIXED = 4'hD;
   // -------------------------------------------------------------------
   // timing
   // -------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int SIR_FIXED_NS = 1600;
   localparam int SIR_FIXED_CYC = SIR_FIXED_NS / CLK_PERIOD_NS;
   localparam int SIR_FRAC_TICKS = 3;
   localparam int REF_KHZ = 125000;
   // -------------------------------------------------------------------
   // types
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_SERIAL = 2'b00,
      MODE_RSVD = 2'b01,
      MODE_ASK = 2'b10,
      MODE_SIR = 2'b11
   } uir_mode_t;
   typedef enum logic [1:0] {
      PS_IDLE = 2'b00,
      PS_FRAC = 2'b01,
      PS_FIXED = 2'b10
   } uir_pulse_t;
endpackage

// File: uir_optic_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------
// optical front end: drives both receive pins, times the led
// ----------------------------------------------------------
module uir_optic_model (
   input wire logic ref_clk,
   input wire logic sirTxPulse,
   input wire logic primLevel,
   input wire logic auxLevel,
   output logic irRxPrimary,
   output logic irRxAux,
   output int pulseCyc,
   output logic pulseDone
);
   int runCnt = 0;
   // detectors always drive their pins, so a level is never left floating
   assign irRxPrimary = primLevel;
   assign irRxAux = auxLevel;
   // led on-time in cycles; done flags the falling end of each pulse
   always @(posedge ref_clk) begin
      pulseDone <= 1'b0;
      if (sirTxPulse) begin
         runCnt <= runCnt + 1;
      end else if (runCnt != 0) begin
         pulseCyc <= runCnt;
         pulseDone <= 1'b1;
         runCnt <= 0;
      end
   end
endmodule

// File: uir_ir_config_test.sv
`timescale 1ns/1ns
module uir_ir_config_test;
   import uir_pkg::*;
   // ----------------------------------------------------------
   // stimulus, outputs and reference model state
   // ----------------------------------------------------------
   logic ref_clk = 0, reset = 1, regWrEn = 0, regRdEn = 0, extendedMode = 0, loopbackEn = 0;
   logic irTxActive = 0, msIrqRaw = 0, baudTick16 = 0, sirPulseReq = 0, cirDemodEn = 0;
   logic primLevel = 0, auxLevel = 0, irRxPrimary, irRxAux, pulseDone;
   logic [2:0] regAddr = 3'h0;
   logic [7:0] regWrData = 8'h00, msrRaw = 8'h00, regRdData, modemStatusReg, linkControlReg, mlink;
   uir_mode_t extModeSel = MODE_SERIAL, activeMode;
   logic irRxData, modemStatusIrq, askTxModEn, askRxDemodEn, sirTxPulse, rxHighSpeedCarrier, carrierAccepted;
   logic [4:0] demodCenterFreq;
   logic [2:0] demodBandwidth, transceiverModeOutputs;
   logic transceiverModeOe;
   logic [8:0] txCarrierKhz;
   logic [7:0] mreg [8][8];
   int bank, n_errors = 0, n_checks = 0, cyc = 0, seed = 90452, pulseCyc;
   int wlist [8] = '{34, 44, 48, 50, 56, 57, 41, 37};

   uir_ir_config dut_u (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
      .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .extendedMode(extendedMode),
      .extModeSel(extModeSel), .loopbackEn(loopbackEn), .irTxActive(irTxActive), .irRxPrimary(irRxPrimary),
      .irRxAux(irRxAux), .msrRaw(msrRaw), .msIrqRaw(msIrqRaw), .baudTick16(baudTick16),
      .sirPulseReq(sirPulseReq), .cirDemodEn(cirDemodEn), .activeMode(activeMode), .irRxData(irRxData),
      .modemStatusReg(modemStatusReg), .modemStatusIrq(modemStatusIrq), .askTxModEn(askTxModEn),
      .askRxDemodEn(askRxDemodEn), .sirTxPulse(sirTxPulse), .demodCenterFreq(demodCenterFreq),
      .demodBandwidth(demodBandwidth), .rxHighSpeedCarrier(rxHighSpeedCarrier),
      .carrierAccepted(carrierAccepted), .txCarrierKhz(txCarrierKhz),
      .transceiverModeOutputs(transceiverModeOutputs), .transceiverModeOe(transceiverModeOe),
      .linkControlReg(linkControlReg));
   uir_optic_model optic_u (.ref_clk(ref_clk), .sirTxPulse(sirTxPulse), .primLevel(primLevel),
      .auxLevel(auxLevel), .irRxPrimary(irRxPrimary), .irRxAux(irRxAux), .pulseCyc(pulseCyc),
      .pulseDone(pulseDone));

   // ----------------------------------------------------------
   // clock, baud ticks and hang guard
   // ----------------------------------------------------------
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end
   // a stuck wait must still reach the verdict, counted as a mismatch
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      baudTick16 <= (cyc % 16 == 0);
      if (cyc == 20000) begin
         n_errors++;
         finish_test();
      end
   end

   // writable bits per bank*8+offset; unlisted places are reserved
   function automatic logic [7:0] wmask(int b, int o);
      case (b * 8 + o)
         34: return 8'h0C;
         44: return 8'h13;
         48: return 8'hE0;
         50: return 8'h0F;
         56, 57, 62: return 8'hFF;
         58: return 8'h60;
         60: return 8'h0F;
         63: return 8'h01;
         default: return 8'h00;
      endcase
   endfunction
   task automatic check(string what, logic [8:0] seen, logic [8:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // one-cycle write; the model mirrors the bank/link split at offset 3
   task automatic wr(logic [2:0] a, logic [7:0] d);
      @(posedge ref_clk);
      regWrEn <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge ref_clk);
      regWrEn <= 1'b0;
      if (a == OFS_LINK && d[7]) begin
         bank = d[2:0];
      end else if (a == OFS_LINK) begin
         mlink = d;
         bank = 0;
      end else begin
         mreg[bank][a] = d & wmask(bank, a);
      end
      #1;
   endtask
   task automatic rd(logic [2:0] a);
      @(posedge ref_clk);
      regRdEn <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRdEn <= 1'b0;
      #1;
      check("read", regRdData, (a == OFS_LINK) ? mlink : mreg[bank][a]);
   endtask
   task automatic rx(logic p, logic x, logic exp);
      @(posedge ref_clk);
      primLevel <= p;
      auxLevel <= x;
      repeat (4) @(posedge ref_clk);
      #1;
      check("rx", irRxData, exp);
   endtask
   task automatic pulse(int lo, int hi);
      int n;
      @(posedge ref_clk);
      sirPulseReq <= 1'b1;
      @(posedge ref_clk);
      sirPulseReq <= 1'b0;
      for (n = 0; n < 300 && pulseDone !== 1'b1; n++) @(posedge ref_clk);
      check("pulse", 9'(pulseCyc >= lo && pulseCyc <= hi), 9'h001);
   endtask
   // three rising edges 2*half apart on the aux detector, then sample
   task automatic carrier(int half, logic exp);
      repeat (3) begin
         @(posedge ref_clk);
         auxLevel <= 1'b0;
         repeat (half) @(posedge ref_clk);
         auxLevel <= 1'b1;
         repeat (half - 1) @(posedge ref_clk);
      end
      repeat (4) @(posedge ref_clk);
      #1;
      check("carrier", carrierAccepted, exp);
   endtask

   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      foreach (mreg[b, o]) mreg[b][o] = 8'h00;
      mreg[4][2] = RST_LEGACY;
      mreg[5][4] = RST_BASIC;
      mreg[6][0] = RST_ASKCTL;
      mreg[6][2] = RST_SIRPW;
      mreg[7][0] = RST_RXDC;
      mreg[7][1] = RST_TXMC;
      mlink = 8'h00;
      bank = 0;
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      // reset contents and reserved offsets of every bank
      for (int b = 4; b < 8; b++) begin
         wr(OFS_LINK, 8'h80 | 8'(b));
         for (int o = 0; o < 8; o++) rd(3'(o));
      end
      // random writes strip reserved bits; link stays shared across banks
      wr(OFS_LINK, 8'h1B);
      foreach (wlist[i]) begin
         wr(OFS_LINK, 8'h80 | 8'(wlist[i] / 8));
         wr(3'(wlist[i] % 8), 8'($random(seed)));
         rd(3'(wlist[i] % 8));
         rd(OFS_LINK);
         check("link", linkControlReg, mlink);
      end
      // legacy select codes, then extended mode overrides them
      wr(OFS_LINK, 8'h84);
      for (int m = 0; m < 4; m++) begin
         wr(OFS_SEL, 8'(m << 2));
         check("mode", activeMode, 9'(m));
      end
      @(posedge ref_clk);
      extendedMode <= 1'b1;
      extModeSel <= MODE_ASK;
      #1;
      check("extmode", activeMode, MODE_ASK);
      wr(OFS_SEL, 8'h00);
      check("extmode", activeMode, MODE_ASK);
      @(posedge ref_clk);
      extendedMode <= 1'b0;
      msrRaw <= 8'($random(seed));
      msIrqRaw <= 1'b1;
      // modem status in an IR mode, in loopback, then in serial mode
      wr(OFS_SEL, 8'h08);
      wr(OFS_LINK, 8'h85);
      wr(OFS_CFG1, 8'h02);
      check("msr", modemStatusReg, MSR_FIXED);
      check("msirq", modemStatusIrq, 9'h000);
      wr(OFS_CFG1, 8'h00);
      check("msr", modemStatusReg, msrRaw);
      @(posedge ref_clk);
      loopbackEn <= 1'b1;
      #1;
      check("msirq", modemStatusIrq, 9'h001);
      wr(OFS_CFG1, 8'h02);
      check("msirq", modemStatusIrq, 9'h000);
      @(posedge ref_clk);
      loopbackEn <= 1'b0;
      wr(OFS_LINK, 8'h84);
      wr(OFS_SEL, 8'h00);
      check("msr", modemStatusReg, msrRaw);
      check("msirq", modemStatusIrq, 9'h001);
      // receive path in SIR mode while transmitting
      wr(OFS_SEL, 8'h0C);
      wr(OFS_LINK, 8'h85);
      wr(OFS_CFG1, 8'h00);
      @(posedge ref_clk);
      irTxActive <= 1'b1;
      rx(1'b1, 1'b0, 1'b0);
      wr(OFS_CFG1, 8'h01);
      rx(1'b1, 1'b0, 1'b1);
      wr(OFS_CFG1, 8'h11);
      rx(1'b0, 1'b1, 1'b1);
      rx(1'b1, 1'b0, 1'b0);
      // SIR pulse codes; receiver unaffected by the code
      wr(OFS_LINK, 8'h86);
      wr(OFS_SEL, {4'h0, SPW_FIXED});
      rx(1'b0, 1'b1, 1'b1);
      pulse(SIR_FIXED_CYC, SIR_FIXED_CYC);
      wr(OFS_SEL, {4'h0, SPW_FRAC});
      pulse(32, 50);
      // ASK modulation and demodulation disables
      wr(OFS_LINK, 8'h84);
      wr(OFS_SEL, 8'h08);
      @(posedge ref_clk);
      sirPulseReq <= 1'b1;
      @(posedge ref_clk);
      sirPulseReq <= 1'b0;
      #1;
      check("nopulse", sirTxPulse, 9'h000);
      wr(OFS_LINK, 8'h86);
      for (int k = 0; k < 4; k++) begin
         wr(OFS_CTL, 8'(k << 6));
         check("askmod", askTxModEn, 9'(!k[0]));
         check("askdem", askRxDemodEn, 9'(!k[1]));
      end
      // demodulator fields, gated by the enable
      // leave ASK mode so the consumer-IR enable governs the demodulator
      wr(OFS_LINK, 8'h84);
      wr(OFS_SEL, 8'h0C);
      wr(OFS_LINK, 8'h87);
      wr(OFS_CTL, 8'($random(seed)));
      @(posedge ref_clk);
      cirDemodEn <= 1'b1;
      #1;
      check("freq", demodCenterFreq, mreg[7][0][4:0]);
      check("bw", demodBandwidth, mreg[7][0][7:5]);
      @(posedge ref_clk);
      cirDemodEn <= 1'b0;
      #1;
      check("freqoff", {demodCenterFreq, demodBandwidth}, 9'h000);
      wr(OFS_SEL, 8'h20);
      check("rxhs", rxHighSpeedCarrier, 9'h001);
      // code 0Bh high speed: 488 kHz nominal, 256 cycles, window +-16
      wr(OFS_CTL, 8'h2B);
      @(posedge ref_clk);
      cirDemodEn <= 1'b1;
      carrier(128, 1'b1);
      @(posedge ref_clk);
      cirDemodEn <= 1'b0;
      carrier(128, 1'b0);
      @(posedge ref_clk);
      cirDemodEn <= 1'b1;
      carrier(100, 1'b0);
      wr(OFS_SEL, 8'h40);
      check("rxhs", rxHighSpeedCarrier, 9'h000);
      wr(OFS_TXM, 8'h0B);
      check("txkhz", txCarrierKhz, 9'h1E0);
      wr(OFS_SEL, 8'h00);
      check("txkhz", txCarrierKhz, 9'h026);
      wr(OFS_TXM, 8'h1D);
      check("txkhz", txCarrierKhz, 9'h038);
      // automatic transceiver config forces mode pins low in serial mode
      wr(OFS_CFG1, 8'h0F);
      wr(OFS_CFG4, 8'h01);
      wr(OFS_LINK, 8'h84);
      wr(OFS_SEL, 8'h00);
      check("modepins", {transceiverModeOe, transceiverModeOutputs}, 9'h008);
      finish_test();
   end
endmodule
